// ===== src/tmr_pkg.sv
// Shared constants and types of the dual 8-bit timer/event counter block.
// Assumes a byte-wide register port with 16-bit addresses and fx equal to clk_sys.
package tmr_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int TMR_CH = 2;
  localparam int TMR_PRE_W = 13;
  localparam int TMR_PIN_W = 12;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] TMR_P1_DIR_ADDR = 16'hff21;
  localparam logic [15:0] TMR_P3_DIR_ADDR = 16'hff23;
  localparam logic [15:0] TMR_P1_LAT_ADDR = 16'hff01;
  localparam logic [15:0] TMR_P3_LAT_ADDR = 16'hff03;
  localparam logic [15:0] TMR_MODE_ADDR [TMR_CH] = '{16'hff6b, 16'hff43};
  localparam logic [15:0] TMR_CMP_ADDR [TMR_CH] = '{16'hff17, 16'hff41};
  localparam logic [15:0] TMR_CNT_ADDR [TMR_CH] = '{16'hff16, 16'hff1f};
  localparam logic [15:0] TMR_CLK_ADDR [TMR_CH] = '{16'hff6a, 16'hff8c};

  // ----------------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------------
  localparam int TMR_RUN_BIT = 7;
  localparam int TMR_PWM_BIT = 6;
  localparam int TMR_LVS_BIT = 3;
  localparam int TMR_LVR_BIT = 2;
  localparam int TMR_TGL_BIT = 1;
  localparam int TMR_OE_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values and fixed patterns
  // ----------------------------------------------------------------------
  localparam logic [7:0] TMR_MODE_RST = 8'h00;
  localparam logic [7:0] TMR_P1_DIR_RST = 8'hff;
  localparam logic [3:0] TMR_P3_DIR_RST = 4'hf;
  localparam logic [3:0] TMR_P3_HI_READ = 4'hf;
  localparam logic [7:0] TMR_P1_LAT_RST = 8'h00;
  localparam logic [3:0] TMR_P3_LAT_RST = 4'h0;
  localparam logic [7:0] TMR_CMP_RST = 8'h00;
  localparam logic [7:0] TMR_CNT_RST = 8'h00;
  localparam logic [2:0] TMR_CLK_RST = 3'h0;
  localparam logic [7:0] TMR_CNT_MAX = 8'hff;
  localparam logic [7:0] TMR_P1_TIMER_MASK = 8'h80;
  localparam logic [3:0] TMR_P3_TIMER_MASK = 4'h8;
  localparam int TMR_PIN_IDX [TMR_CH] = '{7, 11};

  // ----------------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------------
  localparam logic [2:0] TMR_CS_TI_FALL = 3'h0;
  localparam logic [2:0] TMR_CS_TI_RISE = 3'h1;
  localparam int TMR_DIV_EXP [TMR_CH][6] = '{'{0, 1, 2, 6, 8, 13}, '{0, 1, 4, 6, 8, 12}};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic pwm;
    logic tgl_pol;
    logic oe;
  } tmr_mode_type;

  typedef enum logic [2:0] {
    TMR_PWM_WAIT = 3'b001,
    TMR_PWM_ACT = 3'b010,
    TMR_PWM_INACT = 3'b100
  } tmr_pwm_state_type;

endpackage : tmr_pkg

// ===== src/tmr_prescale.sv
// Free-running divider giving one-cycle ticks at clk_sys divided by 2^k.
// Assumes clk_sys stands for fx; tick[0] is high on every cycle.
`timescale 1ns/1ps
module tmr_prescale
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  output logic [TMR_PRE_W:0] tick
);

  logic [TMR_PRE_W-1:0] div_r;

  // Divider counter, never stopped so both timers share one phase
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign tick[0] = 1'b1;

  // A tick of 2^k fires when the low k bits are all ones
  genvar k;
  generate
    for (k = 1; k <= TMR_PRE_W; k++)
    begin : g_tick
      assign tick[k] = &div_r[k-1:0];
    end
  endgenerate

endmodule : tmr_prescale

// ===== src/tmr_sync.sv
// Three-stage synchroniser and edge detector for the port pins.
// Assumes pins are asynchronous to clk_sys; edge flags lag the pin by 2 to 3 cycles, the level by 3 to 4.
`timescale 1ns/1ps
module tmr_sync
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [TMR_PIN_W-1:0] pin_in,
  output logic [TMR_PIN_W-1:0] level,
  output logic [TMR_PIN_W-1:0] rise,
  output logic [TMR_PIN_W-1:0] fall
);

  logic [TMR_PIN_W-1:0] s1_r;
  logic [TMR_PIN_W-1:0] s2_r;
  logic [TMR_PIN_W-1:0] s3_r;
  logic [TMR_PIN_W-1:0] level_r;
  logic [TMR_PIN_W-1:0] level_nxt;

  // A change counts only once stages two and three agree
  assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
  assign rise = level_nxt & ~level_r;
  assign fall = ~level_nxt & level_r;

endmodule : tmr_sync

// ===== src/tmr_timer8.sv
// Two 8-bit timer/event counters with mode control, output flip-flops and pin routing.
// Assumes a single-cycle byte register port and shared port pins on ports 1 and 3.
`timescale 1ns/1ps
module tmr_timer8
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  input wire logic [3:0] p3_in,
  output logic [3:0] p3_out,
  output logic [3:0] p3_oe,
  output logic [TMR_CH-1:0] match_irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [TMR_PRE_W:0] pre_tick;
  logic [TMR_PIN_W-1:0] pin_level;
  logic [TMR_PIN_W-1:0] pin_rise;
  logic [TMR_PIN_W-1:0] pin_fall;

  logic [7:0] p1_dir_r;
  logic [3:0] p3_dir_r;
  logic [7:0] p1_lat_r;
  logic [3:0] p3_lat_r;
  logic [7:0] p1_out_r;
  logic [7:0] p1_oe_r;
  logic [3:0] p3_out_r;
  logic [3:0] p3_oe_r;
  logic [7:0] rdata_r;
  logic [TMR_CH-1:0] irq_r;

  tmr_mode_type mode_r [TMR_CH];
  logic [7:0] cmp_r [TMR_CH];
  logic [7:0] cmp_act_r [TMR_CH];
  logic [7:0] cnt_r [TMR_CH];
  logic [2:0] cs_r [TMR_CH];
  logic [TMR_CH-1:0] tff_r;
  tmr_pwm_state_type pwm_st_r [TMR_CH];

  logic [TMR_CH-1:0] tout;
  logic [7:0] ch_rd [TMR_CH];

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  tmr_prescale u_prescale (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(pre_tick)
  );

  tmr_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in({p3_in, p1_in}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ----------------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------------
  // Address decode for the port registers
  wire wr_p1_dir = reg_wr && (reg_addr == TMR_P1_DIR_ADDR);
  wire wr_p3_dir = reg_wr && (reg_addr == TMR_P3_DIR_ADDR);
  wire wr_p1_lat = reg_wr && (reg_addr == TMR_P1_LAT_ADDR);
  wire wr_p3_lat = reg_wr && (reg_addr == TMR_P3_LAT_ADDR);

  // Direction and output latch storage
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      p1_dir_r <= TMR_P1_DIR_RST;
      p3_dir_r <= TMR_P3_DIR_RST;
      p1_lat_r <= TMR_P1_LAT_RST;
      p3_lat_r <= TMR_P3_LAT_RST;
    end
    else
    begin
      if (wr_p1_dir)
        p1_dir_r <= reg_wdata;
      if (wr_p3_dir)
        p3_dir_r <= reg_wdata[3:0];
      if (wr_p1_lat)
        p1_lat_r <= reg_wdata;
      if (wr_p3_lat)
        p3_lat_r <= reg_wdata[3:0];
    end
  end

  // The timer output is ORed into the latch, so the latch must be 0 to see it
  wire [7:0] p1_out_nxt = p1_lat_r | (TMR_P1_TIMER_MASK & {8{tout[0]}});
  wire [3:0] p3_out_nxt = p3_lat_r | (TMR_P3_TIMER_MASK & {4{tout[1]}});

  // Pin drivers, registered so every output leaves a flip-flop
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      p1_out_r <= '0;
      p3_out_r <= '0;
      p1_oe_r <= '0;
      p3_oe_r <= '0;
    end
    else
    begin
      p1_out_r <= p1_out_nxt;
      p3_out_r <= p3_out_nxt;
      p1_oe_r <= ~p1_dir_r;
      p3_oe_r <= ~p3_dir_r;
    end
  end

  // ----------------------------------------------------------------------
  // Timer channels
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < TMR_CH; i++)
    begin : g_ch
      // Per-channel decode
      wire hit_mode = (reg_addr == TMR_MODE_ADDR[i]);
      wire hit_cmp = (reg_addr == TMR_CMP_ADDR[i]);
      wire hit_cnt = (reg_addr == TMR_CNT_ADDR[i]);
      wire hit_clk = (reg_addr == TMR_CLK_ADDR[i]);
      wire wr_mode = reg_wr && hit_mode;
      wire wr_cmp = reg_wr && hit_cmp;
      wire wr_clk = reg_wr && hit_clk;

      // Level request decoded from the write; 11 matches neither term
      wire lv_set = reg_wdata[TMR_LVS_BIT] && !reg_wdata[TMR_LVR_BIT];
      wire lv_clr = reg_wdata[TMR_LVR_BIT] && !reg_wdata[TMR_LVS_BIT];
      wire lv_ok = wr_mode && !mode_r[i].pwm;

      // Count clock source selection
      logic cnt_tick;
      always_comb
      begin
        cnt_tick = 1'b0;
        case (cs_r[i])
          TMR_CS_TI_FALL: cnt_tick = pin_fall[TMR_PIN_IDX[i]];
          TMR_CS_TI_RISE: cnt_tick = pin_rise[TMR_PIN_IDX[i]];
          3'h2: cnt_tick = pre_tick[TMR_DIV_EXP[i][0]];
          3'h3: cnt_tick = pre_tick[TMR_DIV_EXP[i][1]];
          3'h4: cnt_tick = pre_tick[TMR_DIV_EXP[i][2]];
          3'h5: cnt_tick = pre_tick[TMR_DIV_EXP[i][3]];
          3'h6: cnt_tick = pre_tick[TMR_DIV_EXP[i][4]];
          3'h7: cnt_tick = pre_tick[TMR_DIV_EXP[i][5]];
          default: cnt_tick = 1'b0;
        endcase
      end

      // Counter events
      wire step = mode_r[i].run && cnt_tick;
      wire match = (cnt_r[i] == cmp_act_r[i]);
      wire ovf = (cnt_r[i] == TMR_CNT_MAX);
      wire clr_match = step && match && !mode_r[i].pwm;
      wire [7:0] cnt_inc = cnt_r[i] + 8'h01;
      wire [7:0] cnt_nxt = clr_match ? TMR_CNT_RST : cnt_inc;

      // Mode register; bits 4 and 5 and the set/clear pair are not stored
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          mode_r[i] <= tmr_mode_type'(TMR_MODE_RST[3:0]);
        else if (wr_mode)
        begin
          mode_r[i].run <= reg_wdata[TMR_RUN_BIT];
          mode_r[i].pwm <= reg_wdata[TMR_PWM_BIT];
          mode_r[i].tgl_pol <= reg_wdata[TMR_TGL_BIT];
          mode_r[i].oe <= reg_wdata[TMR_OE_BIT];
        end
      end

      // Clock select keeps only bits 0 to 2
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          cs_r[i] <= TMR_CLK_RST;
        else if (wr_clk)
          cs_r[i] <= reg_wdata[2:0];
      end

      // Compare value; while PWM runs the working copy only reloads at overflow
      // so a mid-cycle rewrite cannot produce a runt pulse
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          cmp_r[i] <= TMR_CMP_RST;
          cmp_act_r[i] <= TMR_CMP_RST;
        end
        else
        begin
          if (wr_cmp)
            cmp_r[i] <= reg_wdata;
          if (!mode_r[i].pwm || !mode_r[i].run || (step && ovf))
            cmp_act_r[i] <= cmp_r[i];
        end
      end

      // Counter: cleared while stopped, cleared on match outside PWM
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          cnt_r[i] <= TMR_CNT_RST;
        else if (!mode_r[i].run)
          cnt_r[i] <= TMR_CNT_RST;
        else if (step)
          cnt_r[i] <= cnt_nxt;
      end

      // Match request, one cycle per counter-compare clear outside PWM
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          irq_r[i] <= 1'b0;
        else
          irq_r[i] <= clr_match;
      end

      // Timer flip-flop; a set or clear write wins over a toggle in the same cycle
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          tff_r[i] <= 1'b0;
        else if (lv_ok && lv_set)
          tff_r[i] <= 1'b1;
        else if (lv_ok && lv_clr)
          tff_r[i] <= 1'b0;
        else if (clr_match && mode_r[i].tgl_pol)
          tff_r[i] <= ~tff_r[i];
      end

      // PWM phase: inactive until the first overflow, then active up to match
      tmr_pwm_state_type pwm_st_nxt;
      always_comb
      begin
        pwm_st_nxt = pwm_st_r[i];
        case (pwm_st_r[i])
          TMR_PWM_WAIT:
            if (step && ovf)
              pwm_st_nxt = (cmp_r[i] == TMR_CNT_RST) ? TMR_PWM_INACT : TMR_PWM_ACT;
          TMR_PWM_ACT:
            if (step && (cnt_inc == cmp_act_r[i]))
              pwm_st_nxt = TMR_PWM_INACT;
          TMR_PWM_INACT:
            if (step && ovf && (cmp_r[i] != TMR_CNT_RST))
              pwm_st_nxt = TMR_PWM_ACT;
          default:
            pwm_st_nxt = TMR_PWM_WAIT;
        endcase
        if (!mode_r[i].run || !mode_r[i].pwm)
          pwm_st_nxt = TMR_PWM_WAIT;
      end

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          pwm_st_r[i] <= TMR_PWM_WAIT;
        else
          pwm_st_r[i] <= pwm_st_nxt;
      end

      // Output selection reacts to the settings whether or not the count runs
      wire pwm_act = (pwm_st_r[i] == TMR_PWM_ACT);
      wire pwm_wave = pwm_act ^ mode_r[i].tgl_pol;
      wire wave = mode_r[i].pwm ? pwm_wave : tff_r[i];
      assign tout[i] = mode_r[i].oe && wave;

      // Read view of this channel; set/clear and bits 4 and 5 read zero
      wire [7:0] mode_rd = {mode_r[i].run, mode_r[i].pwm, 2'b00, 2'b00,
                            mode_r[i].tgl_pol, mode_r[i].oe};
      assign ch_rd[i] = ({8{hit_mode}} & mode_rd)
                      | ({8{hit_cmp}} & cmp_r[i])
                      | ({8{hit_cnt}} & cnt_r[i])
                      | ({8{hit_clk}} & {5'h00, cs_r[i]});
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Port read returns the latch for output bits and the pin for input bits
  wire [7:0] p1_rd = (p1_lat_r & ~p1_dir_r) | (pin_level[7:0] & p1_dir_r);
  wire [3:0] p3_rd = (p3_lat_r & ~p3_dir_r) | (pin_level[11:8] & p3_dir_r);

  // Unmapped addresses answer zero
  wire [7:0] rdata_nxt = ch_rd[0] | ch_rd[1]
                       | ({8{reg_addr == TMR_P1_DIR_ADDR}} & p1_dir_r)
                       | ({8{reg_addr == TMR_P3_DIR_ADDR}} & {TMR_P3_HI_READ, p3_dir_r})
                       | ({8{reg_addr == TMR_P1_LAT_ADDR}} & p1_rd)
                       | ({8{reg_addr == TMR_P3_LAT_ADDR}} & {4'h0, p3_rd});

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= '0;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= '0;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign p1_out = p1_out_r;
  assign p1_oe = p1_oe_r;
  assign p3_out = p3_out_r;
  assign p3_oe = p3_oe_r;
  assign match_irq = irq_r;

endmodule : tmr_timer8

// ===== tb/tmr_timer8_properties.sv
// Checker for the timer block: shadows software writes seen at the register port.
// Assumes the map of tmr_pkg and one-cycle strobes; bound to every tmr_timer8.
`timescale 1ns/1ps
module tmr_timer8_properties
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [3:0] p3_in,
  input wire logic [3:0] p3_out,
  input wire logic [3:0] p3_oe,
  input wire logic [TMR_CH-1:0] match_irq
);
  // ----------------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------------
  logic [7:0] mode_r [TMR_CH];
  logic [7:0] dir1_r;
  logic [7:0] lat1_r;
  logic [3:0] dir3_r;
  logic [2:0] wr_q;
  logic stop_r;
  // Pins lag the registers by a few cycles, so only judge them after a quiet spell
  wire quiet = !reg_wr && (wr_q == 3'h0);

  // Track what software last wrote; write-only and unused bits are never kept
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      mode_r <= '{8'h00, 8'h00};
      dir1_r <= 8'hff;
      lat1_r <= 8'h00;
      dir3_r <= 4'hf;
      wr_q <= 3'h0;
      stop_r <= 1'b1;
    end
    else
    begin
      wr_q <= {wr_q[1:0], reg_wr};
      stop_r <= !mode_r[0][7];
      for (int i = 0; i < TMR_CH; i++)
        if (reg_wr && reg_addr == TMR_MODE_ADDR[i])
          mode_r[i] <= reg_wdata & 8'hc3;
      if (reg_wr && reg_addr == TMR_P1_DIR_ADDR)
        dir1_r <= reg_wdata;
      if (reg_wr && reg_addr == TMR_P1_LAT_ADDR)
        lat1_r <= reg_wdata;
      if (reg_wr && reg_addr == TMR_P3_DIR_ADDR)
        dir3_r <= reg_wdata[3:0];
    end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  reset_pins_off_a: assert property (
    $rose(rstn) |-> p1_oe == 8'h00 && p3_oe == 4'h0 && match_irq == 2'b00)
    else $error("pins driven or request high after reset");
  mode0_read_a: assert property (
    $past(reg_rd && reg_addr == TMR_MODE_ADDR[0]) |-> reg_rdata == $past(mode_r[0]))
    else $error("timer0 mode readback wrong");
  mode1_read_a: assert property (
    $past(reg_rd && reg_addr == TMR_MODE_ADDR[1]) |-> reg_rdata == $past(mode_r[1]))
    else $error("timer1 mode readback wrong");
  dir1_drive_a: assert property (
    quiet |-> p1_oe == ~dir1_r)
    else $error("port1 drive does not follow direction");
  dir3_drive_a: assert property (
    quiet |-> p3_oe == ~dir3_r)
    else $error("port3 drive does not follow direction");
  pin_off_a: assert property (
    quiet && !mode_r[0][0] |-> p1_out[7] == lat1_r[7])
    else $error("timer0 output seen while disabled");
  irq_pwm_a: assert property (
    quiet |-> !(match_irq[0] && mode_r[0][6]) && !(match_irq[1] && mode_r[1][6]))
    else $error("compare request in pwm mode");
  irq_stopped_a: assert property (
    quiet |-> !(match_irq[0] && !mode_r[0][7]) && !(match_irq[1] && !mode_r[1][7]))
    else $error("compare request while stopped");
  count_stop_a: assert property (
    $past(reg_rd && reg_addr == TMR_CNT_ADDR[0] && stop_r && !mode_r[0][7])
      |-> reg_rdata == 8'h00)
    else $error("stopped counter not zero");

  irq0_seen_c: cover property (match_irq[0]);
  irq1_seen_c: cover property (match_irq[1]);
  pwm_high_c: cover property (mode_r[0][6] && mode_r[0][7] && p1_out[7]);
endmodule : tmr_timer8_properties

bind tmr_timer8 tmr_timer8_properties chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p1_in(p1_in),
  .p1_out(p1_out), .p1_oe(p1_oe), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe),
  .match_irq(match_irq)
);

// ===== tb/tmr_pin_model.sv
// Board around the port pins: an event pulse source and the resolved line levels.
// Assumes undriven lines have no pull resistor.
`timescale 1ns/1ps
module tmr_pin_model
  import tmr_pkg::*;
(
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [3:0] p3_out,
  input wire logic [3:0] p3_oe,
  output logic [7:0] p1_in,
  output logic [3:0] p3_in
);
  logic [1:0] ev;
  logic [7:0] noise;
  // Floating lines wander, so a stale level never passes for a driven one
  initial
  begin
    ev = 2'b00;
    noise = 8'h5a;
    forever #13 noise = {noise[6:0], ~noise[7]};
  end
  // A line shows the port driver where enabled, else the outside source
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & {ev[0], noise[6:0]});
  assign p3_in = (p3_oe & p3_out) | (~p3_oe & {ev[1], noise[2:0]});
  // Slow pulses, unrelated in phase to clk_sys, one rise and one fall each
  task automatic pulses(input int ch, input int n);
    repeat (n)
    begin
      #37 ev[ch] = 1'b1;
      #41 ev[ch] = 1'b0;
    end
  endtask : pulses
endmodule : tmr_pin_model

// ===== tb/tmr_timer8_tb.sv
// Self-checking bench for the dual timer block with seeded random traffic.
// Assumes the pin model resolves port lines and the checker is bound to the design.
`timescale 1ns/1ps
module tmr_timer8_tb
  import tmr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, p1_in, p1_out, p1_oe, rv;
  logic [3:0] p3_in, p3_out, p3_oe;
  logic [TMR_CH-1:0] match_irq;
  logic prev;
  int errors = 0;
  int checked = 0;
  int irqs1 = 0;
  int n, cyc;
  // Set/clear table: bit 8 is the pin level each mode write should give
  logic [8:0] lv [6] = '{9'h109, 9'h101, 9'h005, 9'h109, 9'h008, 9'h101};

  always #5 clk_sys = ~clk_sys;
  // Counts timer1 requests for the event tests, away from the edge that launches them
  always @(negedge clk_sys)
    if (match_irq[1] === 1'b1)
      irqs1++;

  tmr_timer8 dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p3_in(p3_in), .p3_out(p3_out),
    .p3_oe(p3_oe), .match_irq(match_irq));
  tmr_pin_model pins_u (.p1_out(p1_out), .p1_oe(p1_oe), .p3_out(p3_out), .p3_oe(p3_oe),
    .p1_in(p1_in), .p3_in(p3_in));

  // ----------------------------------------------------------------------
  // Bus cycles, comparison and expectations
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask : rdchk
  task automatic settle();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Waits for a request, giving up after a bounded count
  task automatic wait_irq(input int ch, output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      #1 c++;
    end
    while (match_irq[ch] !== 1'b1 && c < 9000);
    if (c >= 9000)
    begin
      errors++;
      $display("wrong value at %0t: no compare request", $time);
      close_out();
    end
  endtask : wait_irq
  function automatic logic [7:0] mode_rb(input logic [7:0] d);
    return d & 8'hc3;
  endfunction : mode_rb
  function automatic int gap(input int cmp, input int k);
    return (cmp + 1) << k;
  endfunction : gap

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hf628bf96));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < TMR_CH; i++)
      rdchk(TMR_MODE_ADDR[i], 8'h00, "mode reset");
    rdchk(TMR_P1_DIR_ADDR, 8'hff, "p1 dir reset");
    rdchk(TMR_P3_DIR_ADDR, 8'hff, "p3 dir reset");
    rdchk(16'hff70, 8'h00, "unmapped");
    $display("test reset done");
    // Random stopped settings; unused and write-only bits must read zero
    for (int i = 0; i < 16; i++)
    begin
      rv = 8'($urandom) & 8'h7f;
      if (rv[3])
        rv[2] = 1'b0;
      wr(TMR_MODE_ADDR[i % 2], rv);
      rdchk(TMR_MODE_ADDR[i % 2], mode_rb(rv), "mode readback");
    end
    $display("test readback done");
    // Pin as timer output, then set, clear and enable while stopped
    wr(TMR_P1_DIR_ADDR, 8'h7f);
    wr(TMR_P1_LAT_ADDR, 8'h00);
    wr(TMR_MODE_ADDR[0], 8'h00);
    wr(TMR_MODE_ADDR[0], 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      wr(TMR_MODE_ADDR[0], lv[i][7:0]);
      settle();
      check({7'h00, p1_out[7]}, {7'h00, lv[i][8]}, "level pin");
      check(p1_oe, 8'h80, "p1 drive");
    end
    wr(TMR_MODE_ADDR[0], 8'h40);
    wr(TMR_MODE_ADDR[0], 8'h44);
    wr(TMR_MODE_ADDR[0], 8'h00);
    wr(TMR_MODE_ADDR[0], 8'h01);
    settle();
    check({7'h00, p1_out[7]}, 8'h01, "clear ignored in pwm");
    wr(TMR_MODE_ADDR[0], 8'h41);
    settle();
    check({7'h00, p1_out[7]}, 8'h00, "pwm idle high-active");
    wr(TMR_MODE_ADDR[0], 8'h43);
    settle();
    check({7'h00, p1_out[7]}, 8'h01, "pwm idle low-active");
    $display("test levels done");
    // Interval and square wave on both timers over clock selects 2 to 6
    wr(TMR_MODE_ADDR[0], 8'h00);
    wr(TMR_P3_DIR_ADDR, 8'hf7);
    for (int c = 0; c < TMR_CH; c++)
      for (int s = 2; s < 7; s++)
      begin
        n = 1 + ($urandom % 7);
        wr(TMR_MODE_ADDR[c], 8'h02);
        wr(TMR_CLK_ADDR[c], 8'(s));
        wr(TMR_CMP_ADDR[c], 8'(n));
        wr(TMR_MODE_ADDR[c], 8'h03);
        wr(TMR_MODE_ADDR[c], 8'h07);
        wr(TMR_MODE_ADDR[c], 8'h83);
        wait_irq(c, cyc);
        prev = c ? p3_out[3] : p1_out[7];
        n = gap(n, TMR_DIV_EXP[c][s - 2]);
        for (int j = 0; j < 3; j++)
        begin
          wait_irq(c, cyc);
          check(8'(cyc), 8'(n), "interval");
          check(8'(cyc >> 8), 8'(n >> 8), "long gap");
          rv = {7'h00, c ? p3_out[3] : p1_out[7]};
          check(rv, {7'h00, ~prev}, "square wave");
          prev = rv[0];
        end
        wr(TMR_MODE_ADDR[c], 8'h03);
        rdchk(TMR_CNT_ADDR[c], 8'h00, "stopped count");
      end
    $display("test interval done");
    // Event counting on timer1 from the pin, falling then rising edge
    wr(TMR_P3_DIR_ADDR, 8'hff);
    for (int s = 0; s < 2; s++)
    begin
      wr(TMR_MODE_ADDR[1], 8'h00);
      wr(TMR_CLK_ADDR[1], 8'(s));
      wr(TMR_CMP_ADDR[1], 8'h03);
      wr(TMR_MODE_ADDR[1], 8'h80);
      irqs1 = 0;
      pins_u.pulses(1, 3);
      settle();
      rdchk(TMR_CNT_ADDR[1], 8'h03, "event count");
      pins_u.pulses(1, 1);
      settle();
      rdchk(TMR_CNT_ADDR[1], 8'h00, "event match clears");
      check(8'(irqs1), 8'h01, "event requests");
    end
    $display("test events done");
    // PWM running: active for the compare value out of each 256 ticks
    wr(TMR_MODE_ADDR[0], 8'h40);
    wr(TMR_MODE_ADDR[0], 8'h41);
    wr(TMR_CLK_ADDR[0], 8'h02);
    wr(TMR_CMP_ADDR[0], 8'h40);
    wr(TMR_MODE_ADDR[0], 8'hc1);
    cyc = 0;
    while (p1_out[7] !== 1'b1 && cyc < 600)
    begin
      @(posedge clk_sys);
      #1 cyc++;
    end
    check({7'h00, p1_out[7]}, 8'h01, "pwm start");
    n = 0;
    repeat (512)
    begin
      @(posedge clk_sys);
      #1 n = n + int'(p1_out[7] === 1'b1);
    end
    check(8'(n >> 1), 8'h40, "pwm width");
    wr(TMR_MODE_ADDR[0], 8'h41);
    settle();
    check({7'h00, p1_out[7]}, 8'h00, "pwm stopped");
    $display("test pwm done");
    close_out();
  end
endmodule : tmr_timer8_tb
